// ==== hw/mde_defines.svh ====
// Offsets, timing counts and channel codes for the motor drive external io.
`ifndef MDE_DEFINES_SVH
`define MDE_DEFINES_SVH
`define MDE_CLK_KHZ 200000
`define MDE_MARKER_LOW_NS 2000
`define MDE_MARKER_LOW_CYC \
    ((`MDE_MARKER_LOW_NS * `MDE_CLK_KHZ + 999999) / 1000000)
`define MDE_DAC_KHZ 128
`define MDE_DAC_STEPS 256
`define MDE_DAC_INC (`MDE_DAC_KHZ * `MDE_DAC_STEPS)
`define MDE_SPEED_MID 12'h800
`define MDE_SPEED_MAX 15'h3FFF
`define MDE_SPEED_SHIFT 3
`define MDE_CH_V_CURRENT 2'h0
`define MDE_CH_W_CURRENT 2'h1
`define MDE_CH_DC_BUS 2'h2
`define MDE_CH_SPEED_REF 2'h3
`define MDE_SRC_SIGN_BIT 14
`endif

// ==== hw/mde_pkg.sv ====
// Types shared by the motor drive external io block.
package mde_pkg;
    typedef enum logic [1:0] {
        RUN_STOPPED = 2'b00,
        RUN_RUNNING = 2'b01,
        RUN_ERROR   = 2'b10
    } mde_run_type;
    typedef enum logic [1:0] {
        SCAN_IDLE  = 2'b00,
        SCAN_START = 2'b01,
        SCAN_WAIT  = 2'b10
    } mde_scan_type;
endpackage : mde_pkg

// ==== hw/mde_dac_pwm.sv ====
// One pulse-width modulated diagnostic output channel.
module mde_dac_pwm #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             step_en,
    input  wire logic [WIDTH-1:0] duty,
    output logic                  pwm_out
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] duty_reg;
    logic             pwm_reg;
    wire              wrap = step_en && (cnt_reg == {WIDTH{1'b1}});

    // Duty is taken only at the wrap so a period never carries two values.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            duty_reg <= '0;
            pwm_reg  <= 1'b0;
        end else begin
            if (step_en) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
            if (wrap) begin
                duty_reg <= duty;
            end
            pwm_reg <= (cnt_reg < duty_reg);
        end
    end

    assign pwm_out = pwm_reg;
endmodule : mde_dac_pwm

// ==== hw/mde_external_io.sv ====
// Discrete pins, period marker, A/D scan and diagnostic outputs of a drive.
`include "mde_defines.svh"
module mde_external_io #(
    parameter int NUM_ERRORS = 8,
    parameter int ADC_WIDTH  = 12
) (
    input  wire logic                  CLK,
    input  wire logic                  RST_N,
    input  wire logic                  RUN_CONTROL_PIN,
    input  wire logic                  DIRECTION_PIN,
    input  wire logic                  EMERGENCY_HALT,
    input  wire logic                  ERROR_CLEAR_PIN,
    input  wire logic                  EXTERNAL_PIN_ENABLE,
    input  wire logic                  ERROR_CLEAR_BIT,
    input  wire logic                  HOST_START,
    input  wire logic                  HOST_STOP,
    input  wire logic                  HOST_DIRECTION,
    input  wire logic [13:0]           HOST_TARGET_SPEED,
    input  wire logic                  SPEED_MAP_HIGH,
    input  wire logic [NUM_ERRORS-1:0] ERROR_EVENTS,
    input  wire logic                  PWM_PERIOD_START,
    input  wire logic                  PWM_LOAD,
    input  wire logic [3:0]            MARKERS_PER_LOAD,
    input  wire logic [ADC_WIDTH-1:0]  ADC_DATA,
    input  wire logic                  ADC_DONE,
    input  wire logic [1:0]            DIAG_OUTPUT_SELECT,
    input  wire logic [255:0]          DIAG_SOURCES,
    output logic                       PERIOD_MARKER,
    output logic                       ERROR_OUT,
    output logic [NUM_ERRORS-1:0]      ERROR_STATUS,
    output logic                       PWM_ENABLE,
    output logic                       GATE_ENABLE,
    output logic                       MOTOR_RUNNING,
    output logic                       MOTOR_FORWARD,
    output logic [13:0]                TARGET_SPEED,
    output logic [1:0]                 ADC_MUX_SEL,
    output logic                       ADC_CONVERT,
    output logic [ADC_WIDTH-1:0]       V_CURRENT,
    output logic [ADC_WIDTH-1:0]       W_CURRENT,
    output logic [ADC_WIDTH-1:0]       DC_BUS,
    output logic [ADC_WIDTH-1:0]       SPEED_REF,
    output logic [3:0]                 DIAG_OUT
);
    localparam logic [8:0] LOW_CYC = 9'(`MDE_MARKER_LOW_CYC);
    localparam logic [17:0] DAC_INC = 18'(`MDE_DAC_INC);
    localparam logic [17:0] DAC_MOD = 18'(`MDE_CLK_KHZ);

    function automatic logic [13:0] speed_map(input logic [11:0] x,
                                              input logic        high);
        logic [11:0] d;
        logic [14:0] s;
        d = '0;
        if (high && x >= `MDE_SPEED_MID) begin
            d = x - `MDE_SPEED_MID;
        end else if (!high && x < `MDE_SPEED_MID) begin
            d = `MDE_SPEED_MID - x;
        end
        s = {3'h0, d} << `MDE_SPEED_SHIFT;
        if (s > `MDE_SPEED_MAX) begin
            s = `MDE_SPEED_MAX;
        end
        return s[13:0];
    endfunction : speed_map

    // Offset binary: flipping the sign bit maps -16384 to 0, 16383 to 255.
    function automatic logic [7:0] rescale(input logic [15:0] x);
        return {~x[`MDE_SRC_SIGN_BIT], x[`MDE_SRC_SIGN_BIT-1 -: 7]};
    endfunction : rescale

    // Pin synchronisers; stage one feeds only stage two.
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic       run_s3_reg;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            run_s3_reg <= 1'b0;
        end else begin
            pin_s1_reg <= {ERROR_CLEAR_PIN, EMERGENCY_HALT, DIRECTION_PIN,
                           RUN_CONTROL_PIN};
            pin_s2_reg <= pin_s1_reg;
            run_s3_reg <= pin_s2_reg[0];
        end
    end

    wire ext_en   = EXTERNAL_PIN_ENABLE;
    wire run_s2   = pin_s2_reg[0];
    wire dir_s2   = pin_s2_reg[1];
    wire halt_s2  = pin_s2_reg[2];
    wire clr_s2   = pin_s2_reg[3];
    wire run_rise = ext_en && run_s2 && !run_s3_reg;
    wire run_fall = !run_s2 && run_s3_reg;
    wire start_req = run_rise || HOST_START;
    wire stop_req  = run_fall || HOST_STOP;
    wire err_clear = ERROR_CLEAR_BIT || (ext_en && clr_s2);

    // Error latch; a new event wins over a clear in the same cycle.
    logic [NUM_ERRORS-1:0] error_status_reg;
    logic                  error_out_reg;
    wire [NUM_ERRORS-1:0] error_status_next =
        (error_status_reg & ~{NUM_ERRORS{err_clear}}) | ERROR_EVENTS;
    wire any_err_next = |error_status_next;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            error_status_reg <= '0;
            error_out_reg    <= 1'b0;
        end else begin
            error_status_reg <= error_status_next;
            error_out_reg    <= any_err_next;
        end
    end

    // Run sequencer.
    mde_pkg::mde_run_type run_reg;
    mde_pkg::mde_run_type run_next;
    logic                 forward_reg;
    logic                 pwm_en_reg;
    always_comb begin
        run_next = run_reg;
        if (any_err_next) begin
            run_next = mde_pkg::RUN_ERROR;
        end else if (halt_s2) begin
            run_next = mde_pkg::RUN_STOPPED;
        end else begin
            case (run_reg)
                mde_pkg::RUN_STOPPED: begin
                    if (start_req && !stop_req) begin
                        run_next = mde_pkg::RUN_RUNNING;
                    end
                end
                mde_pkg::RUN_RUNNING: begin
                    if (stop_req) begin
                        run_next = mde_pkg::RUN_STOPPED;
                    end
                end
                mde_pkg::RUN_ERROR: begin
                    run_next = mde_pkg::RUN_STOPPED;
                end
                default: begin
                    run_next = mde_pkg::RUN_STOPPED;
                end
            endcase
        end
    end

    wire starting = (run_reg != mde_pkg::RUN_RUNNING) &&
                    (run_next == mde_pkg::RUN_RUNNING);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_reg     <= mde_pkg::RUN_STOPPED;
            forward_reg <= 1'b1;
            pwm_en_reg  <= 1'b0;
        end else begin
            run_reg    <= run_next;
            pwm_en_reg <= (run_next == mde_pkg::RUN_RUNNING);
            if (starting) begin
                forward_reg <= run_rise ? dir_s2 : HOST_DIRECTION;
            end
        end
    end

    // Period marker: markers are issued on the first MARKERS_PER_LOAD period starts after
    // each load (on every start when it is zero), so a slow host can trade update rate for window count.
    logic [3:0] load_cnt_reg;
    logic [8:0] low_cnt_reg;
    logic       marker_low_reg;
    wire unlimited = (MARKERS_PER_LOAD == 4'h0);
    wire [3:0] load_cnt_eff = PWM_LOAD ? 4'h0 : load_cnt_reg;
    wire issue = PWM_PERIOD_START &&
                 (unlimited || load_cnt_eff < MARKERS_PER_LOAD);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            load_cnt_reg   <= 4'h0;
            low_cnt_reg    <= 9'h000;
            marker_low_reg <= 1'b0;
        end else begin
            if (issue) begin
                load_cnt_reg <= load_cnt_eff + 4'h1;
            end else if (PWM_LOAD) begin
                load_cnt_reg <= 4'h0;
            end
            if (issue) begin
                marker_low_reg <= 1'b1;
                low_cnt_reg    <= LOW_CYC - 9'h001;
            end else if (low_cnt_reg != 9'h000) begin
                low_cnt_reg <= low_cnt_reg - 9'h001;
            end else begin
                marker_low_reg <= 1'b0;
            end
        end
    end

    // A/D scan of the four multiplexed channels.
    mde_pkg::mde_scan_type scan_reg;
    logic [1:0]            ch_reg;
    logic [ADC_WIDTH-1:0]  adc_res_reg [4];
    logic [13:0]           target_reg;
    wire last_ch = (ch_reg == `MDE_CH_SPEED_REF);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            scan_reg <= mde_pkg::SCAN_IDLE;
            ch_reg   <= `MDE_CH_V_CURRENT;
            for (int i = 0; i < 4; i++) begin
                adc_res_reg[i] <= '0;
            end
        end else begin
            case (scan_reg)
                mde_pkg::SCAN_IDLE: begin
                    if (PWM_PERIOD_START) begin
                        ch_reg   <= `MDE_CH_V_CURRENT;
                        scan_reg <= mde_pkg::SCAN_START;
                    end
                end
                mde_pkg::SCAN_START: begin
                    scan_reg <= mde_pkg::SCAN_WAIT;
                end
                mde_pkg::SCAN_WAIT: begin
                    if (ADC_DONE) begin
                        adc_res_reg[ch_reg] <= ADC_DATA;
                        ch_reg   <= ch_reg + 2'h1;
                        scan_reg <= last_ch ? mde_pkg::SCAN_IDLE
                                            : mde_pkg::SCAN_START;
                    end
                end
                default: begin
                    scan_reg <= mde_pkg::SCAN_IDLE;
                end
            endcase
        end
    end

    wire [13:0] mapped = speed_map(adc_res_reg[`MDE_CH_SPEED_REF],
                                   SPEED_MAP_HIGH);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            target_reg <= 14'h0000;
        end else begin
            target_reg <= ext_en ? mapped : HOST_TARGET_SPEED;
        end
    end

    // Diagnostic outputs.
    logic [17:0] dac_acc_reg;
    logic        dac_step_reg;
    logic [7:0]  diag_val_reg [4];
    wire  [18:0] dac_sum = {1'b0, dac_acc_reg} + {1'b0, DAC_INC};
    wire         dac_wrap = (dac_sum >= {1'b0, DAC_MOD});
    // Fractional stepping keeps the average rate exact although the clock
    // is not a whole multiple of the step rate; steps jitter by one cycle.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            dac_acc_reg  <= 18'h00000;
            dac_step_reg <= 1'b0;
        end else begin
            dac_step_reg <= dac_wrap;
            dac_acc_reg  <= dac_wrap ? 18'(dac_sum - {1'b0, DAC_MOD})
                                     : dac_sum[17:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_diag
            wire [3:0]  base = {DIAG_OUTPUT_SELECT, 2'(g)};
            wire [15:0] src  = DIAG_SOURCES[{base, 4'h0} +: 16];
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    diag_val_reg[g] <= 8'h00;
                end else if (issue) begin
                    diag_val_reg[g] <= rescale(src);
                end
            end
            mde_dac_pwm #(
                .WIDTH (8)
            ) u_dac (
                .clk     (CLK),
                .rst_n   (RST_N),
                .step_en (dac_step_reg),
                .duty    (diag_val_reg[g]),
                .pwm_out (DIAG_OUT[g])
            );
        end
    endgenerate

    assign PERIOD_MARKER = !marker_low_reg;
    assign ERROR_OUT     = error_out_reg;
    assign ERROR_STATUS  = error_status_reg;
    assign PWM_ENABLE    = pwm_en_reg;
    assign GATE_ENABLE   = pwm_en_reg;
    assign MOTOR_RUNNING = (run_reg == mde_pkg::RUN_RUNNING);
    assign MOTOR_FORWARD = forward_reg;
    assign TARGET_SPEED  = target_reg;
    assign ADC_MUX_SEL   = ch_reg;
    assign ADC_CONVERT   = (scan_reg == mde_pkg::SCAN_START);
    assign V_CURRENT     = adc_res_reg[`MDE_CH_V_CURRENT];
    assign W_CURRENT     = adc_res_reg[`MDE_CH_W_CURRENT];
    assign DC_BUS        = adc_res_reg[`MDE_CH_DC_BUS];
    assign SPEED_REF     = adc_res_reg[`MDE_CH_SPEED_REF];

    // Checks.
    localparam logic [8:0] LOW_CHK = 9'(`MDE_MARKER_LOW_CYC);
    logic [8:0] low_len_reg;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_len_reg <= 9'h000;
        end else if (issue || PERIOD_MARKER) begin
            low_len_reg <= 9'h000;
        end else begin
            low_len_reg <= low_len_reg + 9'h001;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_pin_start;
        run_rise && run_reg == mde_pkg::RUN_STOPPED && !halt_s2 &&
        !any_err_next && !stop_req;
    endsequence
    sequence s_scan_step;
        scan_reg == mde_pkg::SCAN_WAIT && ADC_DONE && !last_ch;
    endsequence

    property p_marker_fall;
        issue |=> !PERIOD_MARKER;
    endproperty
    a_marker_fall: assert property (p_marker_fall)
        else $error("Marker did not fall at period start.");
    property p_marker_width;
        $rose(PERIOD_MARKER) |-> low_len_reg == LOW_CHK;
    endproperty
    a_marker_width: assert property (p_marker_width)
        else $error("Marker low time is wrong.");
    property p_marker_limit;
        PWM_PERIOD_START && !PWM_LOAD && !unlimited && PERIOD_MARKER &&
        load_cnt_reg >= MARKERS_PER_LOAD |=> PERIOD_MARKER;
    endproperty
    a_marker_limit: assert property (p_marker_limit)
        else $error("Marker issued beyond the per-load count.");
    property p_pin_start;
        s_pin_start |=> MOTOR_RUNNING && PWM_ENABLE &&
                        MOTOR_FORWARD == $past(dir_s2);
    endproperty
    a_pin_start: assert property (p_pin_start)
        else $error("Run rise did not start the motor.");
    property p_pin_stop;
        run_fall |=> !MOTOR_RUNNING;
    endproperty
    a_pin_stop: assert property (p_pin_stop)
        else $error("Run fall did not stop the motor.");
    property p_dir_hold;
        MOTOR_RUNNING && $past(MOTOR_RUNNING) |-> $stable(MOTOR_FORWARD);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("Direction changed while running.");
    property p_halt;
        $rose(EMERGENCY_HALT) |-> ##[1:3] !PWM_ENABLE;
    endproperty
    a_halt: assert property (p_halt)
        else $error("Emergency halt did not disable PWM.");
    property p_pin_clear;
        ext_en && clr_s2 && ERROR_EVENTS == '0 |=> ERROR_STATUS == '0;
    endproperty
    a_pin_clear: assert property (p_pin_clear)
        else $error("Error clear pin did not clear errors.");
    property p_error_out;
        ERROR_OUT == (|ERROR_STATUS);
    endproperty
    a_error_out: assert property (p_error_out)
        else $error("Error output disagrees with status.");
    property p_pins_off;
        !ext_en && run_s2 && !run_s3_reg && !HOST_START &&
        !MOTOR_RUNNING |=> !MOTOR_RUNNING;
    endproperty
    a_pins_off: assert property (p_pins_off)
        else $error("Run pin started motor while pins disabled.");
    property p_scan_begin;
        scan_reg == mde_pkg::SCAN_IDLE && PWM_PERIOD_START |=>
            ADC_CONVERT && ADC_MUX_SEL == `MDE_CH_V_CURRENT;
    endproperty
    a_scan_begin: assert property (p_scan_begin)
        else $error("Scan did not start at period start.");
    property p_scan_next;
        s_scan_step |=> ADC_CONVERT && ADC_MUX_SEL == $past(ch_reg) + 2'h1;
    endproperty
    a_scan_next: assert property (p_scan_next)
        else $error("Scan did not move to the next channel.");
    property p_err_gate;
        (|ERROR_STATUS) |-> !PWM_ENABLE && !GATE_ENABLE;
    endproperty
    a_err_gate: assert property (p_err_gate)
        else $error("Gates on while an error is latched.");
endmodule : mde_external_io

// ==== dv/mde_adc_model.sv ====
// Behavioural model of the multiplexed converter that feeds the scan.
module mde_adc_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        convert,
    input  wire logic [1:0]  mux_sel,
    input  wire logic [11:0] base,
    input  wire logic        slow,
    output logic [11:0]      data,
    output logic             done
);
    timeunit 1ns;
    timeprecision 1ps;
    int          wait_reg;
    logic [11:0] result_reg;
    // Each channel answers a distinct value, so a wrong order shows up.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg   <= 0;
            result_reg <= 12'h000;
            done       <= 1'b0;
            data       <= 12'h000;
        end else begin
            done <= 1'b0;
            data <= ~data;
            if (convert) begin
                wait_reg   <= slow ? 7 : 2;
                result_reg <= base + 12'(mux_sel) * 12'h111;
            end else if (wait_reg > 0) begin
                wait_reg <= wait_reg - 1;
                if (wait_reg == 1) begin
                    done <= 1'b1;
                    data <= result_reg;
                end
            end
        end
    end
endmodule : mde_adc_model

// ==== dv/testbench.sv ====
// Self-checking bench for the drive's discrete, scan and diagnostic io.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 1'b0, rst_n = 1'b0, run_pin = 1'b0, dir_pin = 1'b0;
    logic         halt = 1'b0, clr_pin = 1'b0, pin_en = 1'b0, clr_bit = 1'b0;
    logic         h_start = 1'b0, h_stop = 1'b0, h_dir = 1'b0, map_hi = 1'b0;
    logic         p_start = 1'b0, p_load = 1'b0, slow = 1'b0, adc_done;
    logic         marker, err_out, pwm_en, gate_en, running, forward, conv;
    logic [13:0]  h_speed = 14'h0000, target;
    logic [7:0]   err_ev = 8'h00, err_st, ev;
    logic [3:0]   per_load = 4'h0, diag_out;
    logic [1:0]   sel = 2'h0, mux;
    logic [11:0]  base = 12'h000, adc_data, v_cur, w_cur, dc_bus, spd_ref, v;
    logic [11:0]  corner[3] = '{12'h000, 12'h800, 12'hFFF};
    logic [255:0] src = '0, old;
    int           fail_count = 0, num_checks = 0, hits[4];
    always #2.5 clk = ~clk;
    mde_external_io u_dut (.CLK(clk), .RST_N(rst_n), .RUN_CONTROL_PIN(run_pin),
        .DIRECTION_PIN(dir_pin), .EMERGENCY_HALT(halt),
        .ERROR_CLEAR_PIN(clr_pin), .EXTERNAL_PIN_ENABLE(pin_en),
        .ERROR_CLEAR_BIT(clr_bit), .HOST_START(h_start), .HOST_STOP(h_stop),
        .HOST_DIRECTION(h_dir), .HOST_TARGET_SPEED(h_speed),
        .SPEED_MAP_HIGH(map_hi), .ERROR_EVENTS(err_ev),
        .PWM_PERIOD_START(p_start), .PWM_LOAD(p_load),
        .MARKERS_PER_LOAD(per_load), .ADC_DATA(adc_data), .ADC_DONE(adc_done),
        .DIAG_OUTPUT_SELECT(sel), .DIAG_SOURCES(src), .PERIOD_MARKER(marker),
        .ERROR_OUT(err_out), .ERROR_STATUS(err_st), .PWM_ENABLE(pwm_en),
        .GATE_ENABLE(gate_en), .MOTOR_RUNNING(running),
        .MOTOR_FORWARD(forward), .TARGET_SPEED(target), .ADC_MUX_SEL(mux),
        .ADC_CONVERT(conv), .V_CURRENT(v_cur), .W_CURRENT(w_cur),
        .DC_BUS(dc_bus), .SPEED_REF(spd_ref), .DIAG_OUT(diag_out));
    mde_adc_model u_adc (.clk(clk), .rst_n(rst_n), .convert(conv),
        .mux_sel(mux), .base(base), .slow(slow), .data(adc_data),
        .done(adc_done));
    task automatic test_done();
        if (fail_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse
    task automatic rand_src();
        for (int k = 0; k < 8; k++) begin
            src[32 * k +: 32] = $urandom;
        end
    endtask : rand_src
    function automatic logic [13:0] exp_speed(logic [11:0] x, logic hi);
        int d;
        d = int'(x) - int'(12'h800);
        if (!hi) begin
            d = -d;
        end
        d = (d < 0) ? 0 : d * 8;
        return (d > 16383) ? 14'h3FFF : 14'(d);
    endfunction : exp_speed
    // Exact marker timing, then the four scan results and the speed target.
    task automatic period_check();
        pulse(p_start);
        cyc(1);
        check("marker low", 16'(marker), 16'h0000);
        cyc(398);
        check("marker held", 16'(marker), 16'h0000);
        cyc(1);
        check("marker end", 16'(marker), 16'h0001);
        check("v current", 16'(v_cur), 16'(base));
        check("w current", 16'(w_cur), 16'(base + 12'h111));
        check("dc bus", 16'(dc_bus), 16'(base + 12'h222));
        check("speed ref", 16'(spd_ref), 16'(v));
        check("target", 16'(target), 16'(exp_speed(v, map_hi)));
    endtask : period_check
    // Sources change right after each marker; the old ones must still show.
    task automatic diag_check();
        int d, s;
        for (int g = 0; g < 4; g++) begin
            sel = 2'(g);
            pulse(p_start);
            old = src;
            rand_src();
            cyc(1700);
            hits = '{0, 0, 0, 0};
            repeat (3125) begin
                cyc(1);
                for (int c = 0; c < 4; c++) hits[c] += diag_out[c];
            end
            for (int c = 0; c < 4; c++) begin
                d = int'({~old[16 * (g * 4 + c) + 14],
                          old[16 * (g * 4 + c) + 7 +: 7]});
                s = (hits[c] * 256 + 1562) / 3125;
                s = (s - d <= 1 && d - s <= 1) ? d : s;
                check("diag duty", 16'(s), 16'(d));
            end
        end
    endtask : diag_check
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        test_done();
    end
    initial begin
        void'($urandom(32'h85FBD55B));
        cyc(16);
        rst_n = 1'b1;
        cyc(1);
        check("idle", 16'({marker, forward, running, err_out}), 16'h000C);
        pin_en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            v = (i < 6) ? corner[i % 3] : 12'($urandom);
            map_hi = 1'(i);
            base = v - 12'h333;
            slow = 1'($urandom);
            period_check();
        end
        for (int i = 0; i < 2; i++) begin
            dir_pin = 1'(i);
            run_pin = 1'b1;
            cyc(5);
            check("running", 16'({running, pwm_en}), 16'h0003);
            check("forward", 16'(forward), 16'(i));
            dir_pin = ~dir_pin;
            cyc(5);
            check("forward held", 16'(forward), 16'(i));
            run_pin = 1'b0;
            cyc(5);
            check("stopped", 16'(running), 16'h0000);
        end
        run_pin = 1'b1;
        cyc(5);
        halt = 1'b1;
        cyc(5);
        check("halt pwm", 16'({pwm_en, gate_en}), 16'h0000);
        run_pin = 1'b0;
        cyc(5);
        run_pin = 1'b1;
        cyc(5);
        check("halt start", 16'(pwm_en), 16'h0000);
        halt = 1'b0;
        run_pin = 1'b0;
        pin_en = 1'b0;
        h_speed = 14'($urandom);
        cyc(5);
        check("host target", 16'(target), 16'(h_speed));
        run_pin = 1'b1;
        cyc(5);
        check("pin off start", 16'(running), 16'h0000);
        pulse(h_start);
        cyc(2);
        run_pin = 1'b0;
        cyc(5);
        check("pin off stop", 16'(running), 16'h0000);
        pulse(h_start);
        ev = 8'($urandom) | 8'h01;
        err_ev = ev;
        cyc(1);
        err_ev = 8'h00;
        cyc(20);
        check("err status", 16'(err_st), 16'(ev));
        check("err gates", 16'({err_out, pwm_en, gate_en}), 16'h0004);
        for (int i = 0; i < 2; i++) begin
            pin_en = 1'(i);
            clr_pin = 1'b1;
            cyc(200);
            clr_pin = 1'b0;
            cyc(5);
            v = i ? 12'h000 : 12'({1'b1, ev});
            check("pin clear", 16'({err_out, err_st}), 16'(v));
        end
        err_ev = ev;
        cyc(1);
        err_ev = 8'h00;
        pulse(clr_bit);
        cyc(1);
        check("bit clear", 16'({err_out, err_st}), 16'h0000);
        per_load = 4'h2;
        p_load = 1'b1;
        pulse(p_start);
        p_load = 1'b0;
        for (int i = 0; i < 2; i++) begin
            cyc(410);
            pulse(p_start);
            cyc(1);
            check("per load", 16'(marker), 16'(i));
        end
        per_load = 4'h0;
        cyc(410);
        src[31:0] = 32'h3FFF4000;
        diag_check();
        test_done();
    end
endmodule : testbench
